/* core/tcc_top.sv */
/*
  16-bit timer/counter: clock select, counter, two compare units, capture,
  shared high-byte latch, interrupt enables and flags.
  Assumes an 8-bit register port with one-cycle strobes and read data one
  cycle later, synchronous pins, and a CPU that acks vectors per source.
*/
module tcc_top (
  input  wire logic       MCLK,
  input  wire logic       RESET,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       CAPTURE_INPUT_PIN,
  input  wire logic       EXTERNAL_COUNT_PIN,
  input  wire logic       COMPARATOR_OUT,
  input  wire logic       GLOBAL_IRQ_EN,
  input  wire logic [3:0] IRQ_ACK,
  output logic      [3:0] IRQ_REQ,
  output logic            WAVE_OUTPUT_A,
  output logic            WAVE_OUTPUT_A_OE,
  output logic            WAVE_OUTPUT_B,
  output logic            WAVE_OUTPUT_B_OE
);

  tcc_pkg::tcc_ctrl_a_t ctrl_a_q;
  tcc_pkg::tcc_ctrl_b_t ctrl_b_q;
  logic [7:0]           irq_en_q;
  logic [7:0]           flags_q;
  logic [7:0]           flags_d;
  logic                 cap_src_q;
  logic [7:0]           temp_q;
  logic [7:0]           temp_d;
  logic [15:0]          cnt_q;
  logic [15:0]          cnt_d;
  logic                 down_q;
  logic                 down_d;
  logic [15:0]          cmp_a_q;
  logic [15:0]          cmp_b_q;
  logic [15:0]          cap_q;
  logic                 block_q;
  logic                 wave_a_q;
  logic                 wave_b_q;
  logic [7:0]           rdata_q;
  logic [7:0]           rd_mux;
  logic [15:0]          top;
  tcc_pkg::tcc_kind_t   kind;
  logic                 tick;
  logic [3:0]           taps;
  logic                 ext_edge;
  logic                 cap_pulse;

  // Address decode
  wire logic wr_ctrl_a = WR && (ADDR == tcc_pkg::ADDR_CTRL_A);
  wire logic wr_ctrl_b = WR && (ADDR == tcc_pkg::ADDR_CTRL_B);
  wire logic wr_ctrl_c = WR && (ADDR == tcc_pkg::ADDR_CTRL_C);
  wire logic wr_cnt_l  = WR && (ADDR == tcc_pkg::ADDR_CNT_L);
  wire logic wr_cap_l  = WR && (ADDR == tcc_pkg::ADDR_CAP_L);
  wire logic wr_cmpa_l = WR && (ADDR == tcc_pkg::ADDR_CMPA_L);
  wire logic wr_cmpb_l = WR && (ADDR == tcc_pkg::ADDR_CMPB_L);
  wire logic wr_irq_en = WR && (ADDR == tcc_pkg::ADDR_IRQ_EN);
  wire logic wr_flags  = WR && (ADDR == tcc_pkg::ADDR_IRQ_FLAG);
  wire logic wr_capsrc = WR && (ADDR == tcc_pkg::ADDR_CAP_SRC);
  wire logic wr_high   = WR && (ADDR == tcc_pkg::ADDR_CNT_H || ADDR == tcc_pkg::ADDR_CAP_H ||
                                ADDR == tcc_pkg::ADDR_CMPA_H || ADDR == tcc_pkg::ADDR_CMPB_H);
  wire logic rd_cnt_l  = RD && (ADDR == tcc_pkg::ADDR_CNT_L);
  wire logic rd_cap_l  = RD && (ADDR == tcc_pkg::ADDR_CAP_L);
  wire logic [15:0] wr_word = {temp_q, WDATA};

  // Waveform mode decode
  wire logic [3:0] wgm = {ctrl_b_q.wgm_hi, ctrl_a_q.wgm_lo};
  wire logic cap_is_top = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == 4'hC) || (wgm == 4'hE);
  wire logic tog_ok_a   = (wgm == 4'hE) || (wgm == 4'hF) || (wgm[3:2] == 2'h2);

  always_comb begin
    case (wgm)
      4'h0, 4'h4, 4'hC:             kind = tcc_pkg::KIND_NONPWM;
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9,
      4'hA, 4'hB:                   kind = tcc_pkg::KIND_PHASE;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: kind = tcc_pkg::KIND_FAST;
      default:                      kind = tcc_pkg::KIND_RESERVED;
    endcase
  end

  // Counter limit for each waveform mode
  always_comb begin
    case (wgm)
      4'h1, 4'h5:                   top = tcc_pkg::TOP_8BIT;
      4'h2, 4'h6:                   top = tcc_pkg::TOP_9BIT;
      4'h3, 4'h7:                   top = tcc_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF:       top = cmp_a_q;
      4'h8, 4'hA, 4'hC, 4'hE:       top = cap_q;
      default:                      top = tcc_pkg::CNT_MAX;
    endcase
  end

  // Clock sources
  tcc_prescale u_prescale (
    .clk   (MCLK),
    .rst   (RESET),
    .tap_o (taps)
  );

  // External count pin is read straight from the pad, whatever its direction
  tcc_edge_in u_ext_edge (
    .clk       (MCLK),
    .rst       (RESET),
    .pin       (EXTERNAL_COUNT_PIN),
    .filter_en (1'b0),
    .edge_sel  (ctrl_b_q.clk_sel[0]),
    .event_o   (ext_edge)
  );

  always_comb begin
    case (ctrl_b_q.clk_sel)
      tcc_pkg::CS_STOP:     tick = 1'b0;
      tcc_pkg::CS_DIV1:     tick = 1'b1;
      tcc_pkg::CS_DIV8:     tick = taps[0];
      tcc_pkg::CS_DIV64:    tick = taps[1];
      tcc_pkg::CS_DIV256:   tick = taps[2];
      tcc_pkg::CS_DIV1024:  tick = taps[3];
      tcc_pkg::CS_EXT_FALL,
      tcc_pkg::CS_EXT_RISE: tick = ext_edge;
      default:              tick = 1'b0;
    endcase
  end

  // Capture source: pin or comparator, filtered and edge selected
  tcc_edge_in u_cap_edge (
    .clk       (MCLK),
    .rst       (RESET),
    .pin       (cap_src_q ? COMPARATOR_OUT : CAPTURE_INPUT_PIN),
    .filter_en (ctrl_b_q.filter_en),
    .edge_sel  (ctrl_b_q.edge_sel),
    .event_o   (cap_pulse)
  );

  wire logic cap_ev = cap_pulse && !cap_is_top;

  // Counter events on the timer clock
  wire logic at_top    = (cnt_q == top);
  wire logic at_bottom = (cnt_q == tcc_pkg::CNT_BOTTOM);
  wire logic match_a   = tick && !block_q && (cnt_q == cmp_a_q);
  wire logic match_b   = tick && !block_q && (cnt_q == cmp_b_q);
  wire logic top_ev    = tick && at_top;
  wire logic ov_ev     = tick && ((kind == tcc_pkg::KIND_NONPWM && cnt_q == tcc_pkg::CNT_MAX) ||
                                  (kind == tcc_pkg::KIND_FAST && at_top) ||
                                  (kind == tcc_pkg::KIND_PHASE && down_q && at_bottom));
  wire logic cap_top_ev = top_ev && cap_is_top;
  wire logic non_pwm   = (kind == tcc_pkg::KIND_NONPWM);
  wire logic force_a   = wr_ctrl_c && WDATA[tcc_pkg::BIT_FRC_A] && non_pwm;
  wire logic force_b   = wr_ctrl_c && WDATA[tcc_pkg::BIT_FRC_B] && non_pwm;

  // Counter next value and direction
  always_comb begin
    cnt_d  = cnt_q;
    down_d = down_q;
    if (wr_cnt_l) begin
      cnt_d = wr_word;
    end else if (tick) begin
      if (kind == tcc_pkg::KIND_PHASE) begin
        if (!down_q && at_top) begin
          down_d = 1'b1;
        end else if (down_q && at_bottom) begin
          down_d = 1'b0;
        end
        cnt_d = down_d ? (cnt_q - 16'h0001) : (cnt_q + 16'h0001);
      end else begin
        cnt_d = at_top ? tcc_pkg::CNT_BOTTOM : (cnt_q + 16'h0001);
      end
    end
  end

  // Flags: hardware set wins over vector and write-one clears
  wire logic [7:0] flag_set = ({7'h00, ov_ev} << tcc_pkg::BIT_OV) |
                              ({7'h00, match_a} << tcc_pkg::BIT_CMPA) |
                              ({7'h00, match_b} << tcc_pkg::BIT_CMPB) |
                              ({7'h00, cap_ev | cap_top_ev} << tcc_pkg::BIT_CAP);
  wire logic [7:0] ack_vec  = {2'h0, IRQ_ACK[3], 2'h0, IRQ_ACK[2:0]};
  wire logic [7:0] flag_clr = (wr_flags ? WDATA : 8'h00) | ack_vec;

  assign flags_d = ((flags_q & ~flag_clr) | flag_set) & tcc_pkg::IRQ_MASK;

  // Shared high-byte latch: high writes of any word, low reads of counter or capture
  always_comb begin
    temp_d = temp_q;
    if (wr_high) begin
      temp_d = WDATA;
    end else if (rd_cnt_l) begin
      temp_d = cnt_q[15:8];
    end else if (rd_cap_l) begin
      temp_d = cap_q[15:8];
    end
  end

  // Wave output next value for one compare unit
  function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic hit,
                                     input logic frc, input logic at_t, input logic tog_ok,
                                     input tcc_pkg::tcc_kind_t knd, input logic dn);
    logic nxt;
    nxt = cur;
    case (knd)
      tcc_pkg::KIND_NONPWM: begin
        if (hit || frc) begin
          case (com)
            tcc_pkg::COM_TOGGLE: nxt = ~cur;
            tcc_pkg::COM_CLEAR:  nxt = 1'b0;
            tcc_pkg::COM_SET:    nxt = 1'b1;
            default:             nxt = cur;
          endcase
        end
      end
      tcc_pkg::KIND_FAST: begin
        if (com == tcc_pkg::COM_TOGGLE && tog_ok && hit) begin
          nxt = ~cur;
        end else if (com[1] && at_t) begin
          nxt = ~com[0];
        end else if (com[1] && hit) begin
          nxt = com[0];
        end
      end
      tcc_pkg::KIND_PHASE: begin
        if (com == tcc_pkg::COM_TOGGLE && tog_ok && hit) begin
          nxt = ~cur;
        end else if (com[1] && hit) begin
          nxt = com[0] ^ dn;
        end
      end
      default: nxt = cur;
    endcase
    return nxt;
  endfunction : wave_next

  // Control and interrupt registers
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl_a_q  <= tcc_pkg::REG_RESET;
      ctrl_b_q  <= tcc_pkg::REG_RESET;
      irq_en_q  <= tcc_pkg::REG_RESET;
      flags_q   <= tcc_pkg::REG_RESET;
      cap_src_q <= 1'b0;
      temp_q    <= tcc_pkg::REG_RESET;
    end else begin
      if (wr_ctrl_a) ctrl_a_q <= WDATA & tcc_pkg::CTRL_A_MASK;
      if (wr_ctrl_b) ctrl_b_q <= WDATA & tcc_pkg::CTRL_B_MASK;
      if (wr_irq_en) irq_en_q <= WDATA & tcc_pkg::IRQ_MASK;
      if (wr_capsrc) cap_src_q <= WDATA[0];
      flags_q <= flags_d;
      temp_q  <= temp_d;
    end
  end

  // Counter, compare and capture words
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      cnt_q   <= tcc_pkg::WORD_RESET;
      down_q  <= 1'b0;
      cmp_a_q <= tcc_pkg::WORD_RESET;
      cmp_b_q <= tcc_pkg::WORD_RESET;
      cap_q   <= tcc_pkg::WORD_RESET;
      block_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      down_q  <= down_d;
      block_q <= wr_cnt_l | (block_q & ~tick);
      if (wr_cmpa_l) cmp_a_q <= wr_word;
      if (wr_cmpb_l) cmp_b_q <= wr_word;
      if (wr_cap_l) begin
        cap_q <= wr_word;
      end else if (cap_ev) begin
        cap_q <= cnt_q;
      end
    end
  end

  // Wave outputs and read data
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
      rdata_q  <= tcc_pkg::REG_RESET;
    end else begin
      wave_a_q <= wave_next(wave_a_q, ctrl_a_q.com_a, match_a, force_a, top_ev, tog_ok_a, kind, down_q);
      wave_b_q <= wave_next(wave_b_q, ctrl_a_q.com_b, match_b, force_b, top_ev, 1'b0, kind, down_q);
      rdata_q  <= RD ? rd_mux : tcc_pkg::REG_RESET;
    end
  end

  // Read selection; unmapped addresses read zero
  always_comb begin
    case (ADDR)
      tcc_pkg::ADDR_CTRL_A:   rd_mux = ctrl_a_q;
      tcc_pkg::ADDR_CTRL_B:   rd_mux = ctrl_b_q;
      tcc_pkg::ADDR_CTRL_C:   rd_mux = 8'h00;
      tcc_pkg::ADDR_CNT_L:    rd_mux = cnt_q[7:0];
      tcc_pkg::ADDR_CNT_H,
      tcc_pkg::ADDR_CAP_H:    rd_mux = temp_q;
      tcc_pkg::ADDR_CAP_L:    rd_mux = cap_q[7:0];
      tcc_pkg::ADDR_CMPA_L:   rd_mux = cmp_a_q[7:0];
      tcc_pkg::ADDR_CMPA_H:   rd_mux = cmp_a_q[15:8];
      tcc_pkg::ADDR_CMPB_L:   rd_mux = cmp_b_q[7:0];
      tcc_pkg::ADDR_CMPB_H:   rd_mux = cmp_b_q[15:8];
      tcc_pkg::ADDR_IRQ_EN:   rd_mux = irq_en_q;
      tcc_pkg::ADDR_IRQ_FLAG: rd_mux = flags_q;
      tcc_pkg::ADDR_CAP_SRC:  rd_mux = {7'h00, cap_src_q};
      default:                rd_mux = 8'h00;
    endcase
  end

  // Outputs
  assign RDATA   = rdata_q;
  assign IRQ_REQ = GLOBAL_IRQ_EN ? {flags_q[tcc_pkg::BIT_CAP]  & irq_en_q[tcc_pkg::BIT_CAP],
                                    flags_q[tcc_pkg::BIT_CMPB] & irq_en_q[tcc_pkg::BIT_CMPB],
                                    flags_q[tcc_pkg::BIT_CMPA] & irq_en_q[tcc_pkg::BIT_CMPA],
                                    flags_q[tcc_pkg::BIT_OV]   & irq_en_q[tcc_pkg::BIT_OV]} : 4'h0;
  assign WAVE_OUTPUT_A    = wave_a_q;
  assign WAVE_OUTPUT_B    = wave_b_q;
  assign WAVE_OUTPUT_A_OE = (ctrl_a_q.com_a != tcc_pkg::COM_OFF) &&
                            (non_pwm || ctrl_a_q.com_a != tcc_pkg::COM_TOGGLE || tog_ok_a);
  assign WAVE_OUTPUT_B_OE = (ctrl_a_q.com_b != tcc_pkg::COM_OFF) &&
                            (non_pwm || ctrl_a_q.com_b != tcc_pkg::COM_TOGGLE);

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_cnt_write;
    wr_cnt_l ##1 tick;
  endsequence

  cap_copy_a: assert property (cap_ev && !wr_cap_l |=> cap_q == $past(cnt_q))
    else $error("Capture did not copy the counter");
  cap_off_a: assert property (cap_is_top |-> !cap_ev)
    else $error("Capture event while capture register is top");
  stop_a: assert property (ctrl_b_q.clk_sel == tcc_pkg::CS_STOP && !wr_cnt_l |=> $stable(cnt_q))
    else $error("Counter moved with clock stopped");
  force_flag_a: assert property ($rose(flags_q[tcc_pkg::BIT_CMPA]) |-> $past(match_a))
    else $error("Compare A flag set without a real match");
  ctrl_c_zero_a: assert property (RD && ADDR == tcc_pkg::ADDR_CTRL_C |=> RDATA == 8'h00)
    else $error("Force register did not read zero");
  block_a: assert property (s_cnt_write |-> !match_a && !match_b)
    else $error("Compare match not blocked after counter write");
  irq_req_a: assert property ($rose(flags_q[tcc_pkg::BIT_OV]) && irq_en_q[tcc_pkg::BIT_OV] && GLOBAL_IRQ_EN
                              |-> IRQ_REQ[0])
    else $error("Overflow interrupt not requested");
  ack_clear_a: assert property (IRQ_ACK[1] && !match_a |=> !flags_q[tcc_pkg::BIT_CMPA])
    else $error("Acknowledge did not clear compare A flag");
  hi_latch_a: assert property (rd_cnt_l ##1 (RD && ADDR == tcc_pkg::ADDR_CNT_H) |=> RDATA == $past(cnt_q, 2) >> 8)
    else $error("High byte does not match latched counter");

endmodule : tcc_top

/* include/tcc_pkg.sv */
/*
  Shared constants and types of the 16-bit timer with capture and compare.
  Assumes an 8-bit register port on one clock and a synchronous reset.
*/
package tcc_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] ADDR_CTRL_A   = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h81;
  localparam logic [7:0] ADDR_CTRL_C   = 8'h82;
  localparam logic [7:0] ADDR_CNT_L    = 8'h84;
  localparam logic [7:0] ADDR_CNT_H    = 8'h85;
  localparam logic [7:0] ADDR_CAP_L    = 8'h86;
  localparam logic [7:0] ADDR_CAP_H    = 8'h87;
  localparam logic [7:0] ADDR_CMPA_L   = 8'h88;
  localparam logic [7:0] ADDR_CMPA_H   = 8'h89;
  localparam logic [7:0] ADDR_CMPB_L   = 8'h8A;
  localparam logic [7:0] ADDR_CMPB_H   = 8'h8B;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h8C;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h8D;
  localparam logic [7:0] ADDR_CAP_SRC  = 8'h8E;

  // Field positions
  localparam int BIT_CAP   = 5;
  localparam int BIT_CMPB  = 2;
  localparam int BIT_CMPA  = 1;
  localparam int BIT_OV    = 0;
  localparam int BIT_FRC_A = 7;
  localparam int BIT_FRC_B = 6;

  // Writable bits of each control register and reset values
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'hDF;
  localparam logic [7:0] IRQ_MASK    = 8'h27;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // Clock source codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler taps: counter bits whose all-ones state ends a period of 8, 64, 256, 1024
  localparam int PRESCALE_BITS = 10;
  localparam int PRESCALE_TAPS = 4;
  localparam int TAP_BITS [PRESCALE_TAPS] = '{3, 6, 8, 10};

  // Capture filter length in samples
  localparam int FILTER_SAMPLES = 4;

  // Fixed counter limits
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;

  // Compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // Control register layouts
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [1:0] rsvd;
    logic [1:0] wgm_lo;
  } tcc_ctrl_a_t;

  typedef struct packed {
    logic       filter_en;
    logic       edge_sel;
    logic       rsvd;
    logic [1:0] wgm_hi;
    logic [2:0] clk_sel;
  } tcc_ctrl_b_t;

  // Counting family chosen by the waveform mode
  typedef enum logic [1:0] {
    KIND_NONPWM,
    KIND_FAST,
    KIND_PHASE,
    KIND_RESERVED
  } tcc_kind_t;

endpackage : tcc_pkg

/* core/tcc_prescale.sv */
/*
  Free-running prescaler giving one-cycle enable pulses at the tap rates.
  Assumes one clock and a synchronous active-high reset.
*/
module tcc_prescale #(
  parameter int WIDTH = tcc_pkg::PRESCALE_BITS
) (
  input  wire logic                              clk,
  input  wire logic                              rst,
  output logic [tcc_pkg::PRESCALE_TAPS-1:0]      tap_o
);

  logic [WIDTH-1:0] div_q;

  // Divider runs regardless of the selected clock source
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + WIDTH'(1);
    end
  end

  // Each tap pulses when its low counter bits are all ones
  for (genvar i = 0; i < tcc_pkg::PRESCALE_TAPS; i++) begin : g_tap
    assign tap_o[i] = &div_q[tcc_pkg::TAP_BITS[i]-1:0];
  end

  div8_period_a: assert property (@(posedge clk) disable iff (rst)
    tap_o[0] |=> (!tap_o[0])[*7] ##1 tap_o[0])
    else $error("Divide-by-8 tap period is not eight cycles");

endmodule : tcc_prescale

/* core/tcc_edge_in.sv */
/*
  Pin sampler with optional four-sample noise filter and edge selection.
  Assumes the pin is synchronous to the clock; one-cycle event pulse out.
*/
module tcc_edge_in #(
  parameter int SAMPLES = tcc_pkg::FILTER_SAMPLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic filter_en,
  input  wire logic edge_sel,
  output logic      event_o
);

  logic               sample_q;
  logic [SAMPLES-2:0] hist_q;
  logic               filt_q;
  logic               prev_q;
  wire logic [SAMPLES-1:0] window = {hist_q, sample_q};
  wire logic          all_eq = (&window) | (~|window);
  wire logic          level  = filter_en ? filt_q : sample_q;

  // Sample history, filtered level and previous level for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_q <= 1'b0;
      hist_q   <= '0;
      filt_q   <= 1'b0;
      prev_q   <= 1'b0;
    end else begin
      sample_q <= pin;
      hist_q   <= window[SAMPLES-2:0];
      if (all_eq) begin
        filt_q <= sample_q;
      end
      prev_q   <= level;
    end
  end

  // Rising edge when edge_sel is one, falling edge otherwise
  assign event_o = edge_sel ? (level & ~prev_q) : (~level & prev_q);

  filter_hold_a: assert property (@(posedge clk) disable iff (rst)
    $changed(filt_q) |-> ($past(sample_q, 1) == filt_q) && ($past(sample_q, 2) == filt_q)
                         && ($past(sample_q, 3) == filt_q) && ($past(sample_q, 4) == filt_q))
    else $error("Filtered level changed without four equal samples");

endmodule : tcc_edge_in

/* dv/tcc_pins.sv */
/*
  Pin-side partner: drives the capture pin and the external count pin.
  Assumes the bench requests levels; pins move just after MCLK rises.
*/
module tcc_pins (
  input  wire logic clk,
  input  wire logic cap_req,
  input  wire logic ext_req,
  output logic      cap_pin = 1'b0,
  output logic      ext_pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins follow the requested levels one clock later
  always @(posedge clk) begin
    cap_pin <= cap_req;
    ext_pin <= ext_req;
  end
endmodule : tcc_pins

/* dv/tcc_top_bench.sv */
/*
  Self-checking bench of the 16-bit timer: registers, compare, capture, counting.
  Assumes tcc_pkg, tcc_top and the pin partner are compiled first.
*/
module tcc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, gie = 1'b1;
  logic       cap_req = 1'b0, ext_req = 1'b0, src = 1'b0, cap_pin, ext_pin, wa, wa_oe, wb, wb_oe;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
  logic [3:0] ack = 4'h0, irq;
  logic [15:0] x;
  int          miscompares = 0, n_checks = 0, seed = 43, v;
  int          dv [4] = '{8, 64, 256, 1024};
  logic [7:0]  zr [7] = '{8'h80, 8'h81, 8'h82, 8'h8C, 8'h8D, 8'h84, 8'hF0};

  // Clock at 25 MHz
  always #20 mclk = ~mclk;

  tcc_top uut (.MCLK(mclk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .CAPTURE_INPUT_PIN(cap_pin & ~src), .EXTERNAL_COUNT_PIN(ext_pin), .COMPARATOR_OUT(cap_pin & src),
    .GLOBAL_IRQ_EN(gie), .IRQ_ACK(ack), .IRQ_REQ(irq), .WAVE_OUTPUT_A(wa), .WAVE_OUTPUT_A_OE(wa_oe),
    .WAVE_OUTPUT_B(wb), .WAVE_OUTPUT_B_OE(wb_oe));
  tcc_pins pins (.clk(mclk), .cap_req(cap_req), .ext_req(ext_req), .cap_pin(cap_pin), .ext_pin(ext_pin));

  task automatic chk(input string nm, input logic [15:0] seen, input int exp);
    n_checks++;
    if (seen !== exp[15:0]) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp[15:0], seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr8

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd8

  // Word access: high byte first on writes, low byte first on reads
  task automatic wr16(input logic [7:0] a, input int d);
    wr8(a + 8'h01, d[15:8]);
    wr8(a, d[7:0]);
  endtask : wr16

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    addr <= a + 8'h01;
    #1 d[7:0] = rdata;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d[15:8] = rdata;
  endtask : rd16

  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Cuts a hung run short
  initial begin
    cyc(60000);
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial begin
    cyc(5);
    reset <= 1'b0;
    wr8(8'hF0, 8'hFF);
    foreach (zr[i]) begin
      rd8(zr[i], r);
      chk("reset_zero", r, 0);
    end
    // Forced toggle of waves A and B, no flag
    wr8(tcc_pkg::ADDR_CTRL_A, 8'h50);
    wr8(tcc_pkg::ADDR_CTRL_C, 8'hC0);
    cyc(2);
    chk("force_wave", {wb_oe, wb, wa_oe, wa}, 4'hF);
    rd8(tcc_pkg::ADDR_CTRL_C, r);
    chk("force_read", r, 0);
    rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
    chk("force_flag", r, 0);
    // Compare match, request, acknowledge
    wr8(tcc_pkg::ADDR_IRQ_EN, 8'h27);
    wr16(tcc_pkg::ADDR_CMPA_L, 16'h0010);
    wr16(tcc_pkg::ADDR_CNT_L, 0);
    rd16(tcc_pkg::ADDR_CNT_L, x);
    chk("count_word", x, 0);
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h01);
    cyc(30);
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h00);
    rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
    chk("match_flag", r, 8'h02);
    chk("match_wave", {irq, wa}, 8'h04);
    cyc(1);
    ack <= 4'h2;
    cyc(1);
    ack <= 4'h0;
    cyc(1);
    chk("ack_clear", irq, 0);
    // Prescaler taps give nine to eleven ticks in ten periods
    for (int k = 0; k < 4; k++) begin
      wr16(tcc_pkg::ADDR_CNT_L, 16'h0100);
      wr8(tcc_pkg::ADDR_CTRL_B, 8'(k + 2));
      cyc(10 * dv[k]);
      wr8(tcc_pkg::ADDR_CTRL_B, 8'h00);
      rd16(tcc_pkg::ADDR_CNT_L, x);
      chk("prescale", x >= 16'h0109 && x <= 16'h010B, 1);
    end
    // Capture on each edge, with and without the filter
    for (int i = 0; i < 4; i++) begin
      wr8(tcc_pkg::ADDR_CAP_SRC, 8'(i[1]));
      src <= i[1];
      v = $random(seed) & 16'hFFFF;
      wr16(tcc_pkg::ADDR_CNT_L, v);
      wr8(tcc_pkg::ADDR_CTRL_B, {i[1], i[0], 6'h00});
      cap_req <= ~i[0];
      cyc(8);
      wr8(tcc_pkg::ADDR_IRQ_FLAG, 8'h27);
      if (i[1]) begin
        cap_req <= i[0];
        cyc(2);
        cap_req <= ~i[0];
        cyc(8);
      end
      cap_req <= i[0];
      cyc(3);
      rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
      chk("cap_early", r, i[1] ? 0 : 8'h20);
      cyc(10);
      rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
      chk("cap_flag", r, 8'h20);
      rd16(tcc_pkg::ADDR_CAP_L, x);
      chk("cap_value", x, v);
    end
    // Capture register as top: pin edges ignored
    wr8(tcc_pkg::ADDR_IRQ_FLAG, 8'h27);
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h58);
    cap_req <= 1'b0;
    cyc(4);
    cap_req <= 1'b1;
    cyc(10);
    rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
    chk("cap_off", r, 0);
    // Counter write blocks the next match
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h00);
    wr16(tcc_pkg::ADDR_CMPB_L, 16'h0050);
    wr16(tcc_pkg::ADDR_CNT_L, 16'h0100);
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h01);
    wr16(tcc_pkg::ADDR_CNT_L, 16'h0050);
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h00);
    rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
    chk("blocked", r, 0);
    // Overflow at the maximum count
    wr16(tcc_pkg::ADDR_CNT_L, 16'hFFF0);
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h01);
    cyc(20);
    wr8(tcc_pkg::ADDR_CTRL_B, 8'h00);
    rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
    chk("overflow", {irq, r}, 12'h101);
    cyc(1);
    gie <= 1'b0;
    cyc(2);
    chk("global_off", irq, 0);
    wr8(tcc_pkg::ADDR_IRQ_FLAG, 8'h01);
    rd8(tcc_pkg::ADDR_IRQ_FLAG, r);
    chk("w1c", r, 0);
    // External pin edges, falling then rising
    for (int c = 6; c < 8; c++) begin
      wr16(tcc_pkg::ADDR_CNT_L, 0);
      wr8(tcc_pkg::ADDR_CTRL_B, 8'(c));
      repeat (5) begin
        ext_req <= 1'b1;
        cyc(3);
        ext_req <= 1'b0;
        cyc(3);
      end
      wr8(tcc_pkg::ADDR_CTRL_B, 8'h00);
      rd16(tcc_pkg::ADDR_CNT_L, x);
      chk("ext_count", x, 5);
    end
    complete_run();
  end
endmodule : tcc_top_bench
